// *** src/spr_pkg.sv ***
// constants, register map and state type of the stall prevention ramp supervisor
package spr_pkg;
    // register indices; byte address is four times the index
    localparam logic [13:0] IDX_OV_LEVEL = 14'h0601;
    localparam logic [13:0] IDX_OV_MODE  = 14'h0602;
    localparam logic [13:0] IDX_ACC_LIM  = 14'h0603;
    localparam logic [13:0] IDX_RUN_LIM  = 14'h0604;
    localparam logic [13:0] IDX_RAMP_SEL = 14'h0605;
    localparam logic [13:0] IDX_CTRL     = 14'h0610;
    localparam logic [13:0] IDX_STATUS   = 14'h0611;
    localparam logic [13:0] IDX_FREQ     = 14'h0612;
    // mode codes and control fields
    localparam logic [15:0] MODE_TRAD    = 16'h0000;
    localparam logic [15:0] MODE_SMART   = 16'h0001;
    localparam int          CTRL_DUTY_BIT = 0;
    localparam int          CTRL_HV_BIT   = 1;
    // reset values, limits in percent, voltages in 0.1 V
    localparam logic [15:0] RST_OV_MODE  = 16'h0000;
    localparam logic [15:0] RST_LVL_LV   = 16'h0ed8;
    localparam logic [15:0] RST_LVL_HV   = 16'h1db0;
    localparam logic [15:0] RST_LIM_VT   = 16'h0078;
    localparam logic [15:0] RST_LIM_CT   = 16'h00b4;
    localparam logic [15:0] MAX_LIM_VT   = 16'h0096;
    localparam logic [15:0] MAX_LIM_CT   = 16'h00c8;
    localparam logic [15:0] LIM_HIGHBUS  = 16'h00b9;
    localparam logic [15:0] HIGHBUS_HV   = 16'h1b58;
    localparam logic [15:0] HIGHBUS_LV   = 16'h0dac;
    localparam logic [31:0] PCT_FULL     = 32'h0000_0064;
    localparam logic [15:0] SMART_BAND   = 16'h00c8;
    // bus responses
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;
    // ramp states, one-hot
    typedef enum logic [4:0] {
        ST_STEADY  = 5'h01,
        ST_ACCEL   = 5'h02,
        ST_DECEL   = 5'h04,
        ST_RUNLIM  = 5'h08,
        ST_RECOVER = 5'h10
    } spr_state_t;
endpackage : spr_pkg

// *** src/spr_axil_slave.sv ***
// axi4-lite slave front end that turns bus transfers into register strobes
`timescale 1ns/1ns
`default_nettype none
module spr_axil_slave
    import spr_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic [15:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [15:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             wr_en,
    output logic [13:0]      wr_idx,
    output logic [15:0]      wr_data,
    input  wire logic        wr_ok,
    output logic [13:0]      rd_idx,
    input  wire logic [31:0] rd_data,
    input  wire logic        rd_ok
);
    logic        aw_have_q;
    logic        w_have_q;
    logic [13:0] aw_idx_q;
    logic [15:0] w_data_q;

    // address and data are captured in either order, write fires when both held
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            aw_have_q    <= 1'b0;
            w_have_q     <= 1'b0;
            aw_idx_q     <= 14'h0000;
            w_data_q     <= 16'h0000;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_idx_q  <= s_axi_awaddr[15:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata[15:0];
            end
            if (wr_en) begin
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // write strobes are ignored; the low half-word of write data is always written whole
    assign wr_en         = aw_have_q && w_have_q && !s_axi_bvalid;
    assign wr_idx        = aw_idx_q;
    assign wr_data       = w_data_q;
    assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
    assign rd_idx        = s_axi_araddr[15:2];
    assign s_axi_arready = !s_axi_rvalid;

    // read data registered one cycle after the address is taken
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_ok ? rd_data : 32'h0000_0000;
            s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    logic unused_strb;
    assign unused_strb = ^s_axi_wstrb ^ ^s_axi_wdata[31:16];
endmodule : spr_axil_slave
`default_nettype wire

// *** src/spr_ramp_ctrl.sv ***
// stall prevention supervisor for the drive's output frequency ramp
// What this block does
// - mode register: 0 traditional, 1 smart over-voltage stall; resets to 0.
// - traditional: pause deceleration while bus voltage is high, resume below stall level.
// - smart: halve deceleration step while bus voltage is in the band below the stall level.
// - over-voltage during deceleration stretches deceleration until the motor stops.
// - accel limit accepts 0..150 variable torque (120), 0..200 constant torque (180).
// - constant torque on high bus clamps accel limit to 185 percent.
// - accelerating above accel limit freezes frequency until current falls to or below it.
// - steady running above run limit decelerates at the selected stall ramp.
// - after run-limit reduction, current below limit re-accelerates to command.
// - run limit accepts 0..150 variable torque (120), 0..200 constant torque (180).
// - constant torque on high bus clamps run limit to 185 percent.
// - limit of 100 equals rated drive current against measured current.
// - stall level of zero disables over-voltage stall in both modes.
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module spr_ramp_ctrl
    import spr_pkg::*;
#(
    parameter bit HV_MODEL = 1'b1,
    parameter bit CT_DUTY  = 1'b0
)(
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic [15:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [15:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        sample_valid,
    input  wire logic [15:0] bus_voltage,
    input  wire logic [15:0] out_current,
    input  wire logic [15:0] rated_current,
    input  wire logic [15:0] freq_cmd,
    input  wire logic [15:0] accel_step,
    input  wire logic [15:0] decel_step,
    input  wire logic [15:0] stall_step,
    output logic [15:0]      out_freq_q,
    output logic             ramp_hold_q,
    output logic             decel_extended_q
);
    import spr_pkg::*;

    logic        wr_en;
    logic [13:0] wr_idx;
    logic [15:0] wr_data;
    logic        wr_ok;
    logic [13:0] rd_idx;
    logic [31:0] rd_data;
    logic        rd_ok;

    logic [15:0] ov_level_q;
    logic [15:0] ov_mode_q;
    logic [15:0] acc_lim_q;
    logic [15:0] run_lim_q;
    logic [15:0] ramp_sel_q;
    logic        duty_ct_q;
    logic        hv_model_q;

    logic        ov_hi_q;
    logic        ov_near_q;
    logic        acc_oc_q;
    logic        run_oc_q;
    logic        tick_q;
    spr_state_t  state_q;

    spr_axil_slave u_bus (
        .clk_sys       (clk_sys),
        .sys_rst       (sys_rst),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wr_en         (wr_en),
        .wr_idx        (wr_idx),
        .wr_data       (wr_data),
        .wr_ok         (wr_ok),
        .rd_idx        (rd_idx),
        .rd_data       (rd_data),
        .rd_ok         (rd_ok)
    );

    // range ceiling of the limit registers follows the torque duty
    logic [15:0] lim_max;
    assign lim_max = duty_ct_q ? MAX_LIM_CT : MAX_LIM_VT;

    // write decode; status and frequency are read-only
    assign wr_ok = (wr_idx == IDX_OV_LEVEL) || (wr_idx == IDX_OV_MODE)
                || (wr_idx == IDX_ACC_LIM) || (wr_idx == IDX_RUN_LIM)
                || (wr_idx == IDX_RAMP_SEL) || (wr_idx == IDX_CTRL);

    // parameter registers; oversize limit writes saturate at the ceiling
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ov_mode_q  <= RST_OV_MODE;
            ov_level_q <= HV_MODEL ? RST_LVL_HV : RST_LVL_LV;
            acc_lim_q  <= CT_DUTY ? RST_LIM_CT : RST_LIM_VT;
            run_lim_q  <= CT_DUTY ? RST_LIM_CT : RST_LIM_VT;
            ramp_sel_q <= 16'h0000;
            duty_ct_q  <= CT_DUTY;
            hv_model_q <= HV_MODEL;
        end else if (wr_en) begin
            case (wr_idx)
                IDX_OV_LEVEL: ov_level_q <= wr_data;
                IDX_OV_MODE:  ov_mode_q  <= {15'h0000, wr_data[0]};
                IDX_ACC_LIM:  acc_lim_q  <= (wr_data > lim_max) ? lim_max : wr_data;
                IDX_RUN_LIM:  run_lim_q  <= (wr_data > lim_max) ? lim_max : wr_data;
                IDX_RAMP_SEL: ramp_sel_q <= {15'h0000, wr_data[0]};
                IDX_CTRL:
                begin
                    duty_ct_q  <= wr_data[CTRL_DUTY_BIT];
                    hv_model_q <= wr_data[CTRL_HV_BIT];
                end
                default: ;
            endcase
        end
    end

    // read mux, answered one cycle later by the slave
    always_comb begin
        rd_ok   = 1'b1;
        rd_data = 32'h0000_0000;
        case (rd_idx)
            IDX_OV_LEVEL: rd_data = {16'h0000, ov_level_q};
            IDX_OV_MODE:  rd_data = {16'h0000, ov_mode_q};
            IDX_ACC_LIM:  rd_data = {16'h0000, acc_lim_q};
            IDX_RUN_LIM:  rd_data = {16'h0000, run_lim_q};
            IDX_RAMP_SEL: rd_data = {16'h0000, ramp_sel_q};
            IDX_CTRL:     rd_data = {30'h0000_0000, hv_model_q, duty_ct_q};
            IDX_STATUS:   rd_data = {21'h000000, state_q, decel_extended_q, ramp_hold_q,
                                     run_oc_q, acc_oc_q, ov_near_q, ov_hi_q};
            IDX_FREQ:     rd_data = {16'h0000, out_freq_q};
            default:      rd_ok   = 1'b0;
        endcase
    end

    // effective limits, clamped on a high bus in constant torque duty
    logic        bus_high;
    logic [15:0] acc_lim_eff;
    logic [15:0] run_lim_eff;
    assign bus_high    = bus_voltage > (hv_model_q ? HIGHBUS_HV : HIGHBUS_LV);
    assign acc_lim_eff = (duty_ct_q && bus_high && acc_lim_q > LIM_HIGHBUS)
                       ? LIM_HIGHBUS : acc_lim_q;
    assign run_lim_eff = (duty_ct_q && bus_high && run_lim_q > LIM_HIGHBUS)
                       ? LIM_HIGHBUS : run_lim_q;

    // current in percent of rated: cur*100 against limit*rated
    logic [31:0] cur_pct;
    logic [31:0] acc_thr;
    logic [31:0] run_thr;
    assign cur_pct = {16'h0000, out_current} * PCT_FULL;
    assign acc_thr = {16'h0000, acc_lim_eff} * {16'h0000, rated_current};
    assign run_thr = {16'h0000, run_lim_eff} * {16'h0000, rated_current};

    // band below the level in which smart mode starts easing off
    logic [15:0] near_lvl;
    assign near_lvl = (ov_level_q > SMART_BAND) ? (ov_level_q - SMART_BAND) : 16'h0000;

    // compare flags latched once per control sample, tick marks the decision cycle
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ov_hi_q   <= 1'b0;
            ov_near_q <= 1'b0;
            acc_oc_q  <= 1'b0;
            run_oc_q  <= 1'b0;
            tick_q    <= 1'b0;
        end else begin
            tick_q <= sample_valid;
            if (sample_valid) begin
                ov_hi_q   <= (ov_level_q != 16'h0000) && (bus_voltage >= ov_level_q);
                ov_near_q <= (ov_level_q != 16'h0000) && (bus_voltage >= near_lvl);
                acc_oc_q  <= cur_pct > acc_thr;
                run_oc_q  <= cur_pct > run_thr;
            end
        end
    end

    // step sizes: constant-speed stall ramp picks the normal or stall step
    logic [15:0] up_step;
    logic [15:0] dn_step;
    logic [15:0] stall_up;
    logic [15:0] stall_dn;
    logic [15:0] smart_dn;
    logic        smart;
    assign smart    = ov_mode_q[0];
    assign stall_up = ramp_sel_q[0] ? stall_step : accel_step;
    assign stall_dn = ramp_sel_q[0] ? stall_step : decel_step;
    assign smart_dn = (ov_near_q && decel_step > 16'h0001) ? {1'b0, decel_step[15:1]}
                    : decel_step;
    assign up_step  = (freq_cmd - out_freq_q < accel_step) ? freq_cmd - out_freq_q
                                                           : accel_step;
    assign dn_step  = (out_freq_q - freq_cmd < smart_dn) ? out_freq_q - freq_cmd
                                                         : smart_dn;

    // ramp state machine and output frequency, advanced on the decision tick
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_q     <= ST_STEADY;
            out_freq_q  <= 16'h0000;
            ramp_hold_q <= 1'b0;
        end else if (tick_q) begin
            ramp_hold_q <= 1'b0;
            case (state_q)
                ST_STEADY:
                begin
                    if (run_oc_q && out_freq_q != 16'h0000) begin
                        state_q    <= ST_RUNLIM;
                        out_freq_q <= (out_freq_q > stall_dn) ? out_freq_q - stall_dn
                                                              : 16'h0000;
                    end else if (freq_cmd > out_freq_q) begin
                        state_q <= ST_ACCEL;
                    end else if (freq_cmd < out_freq_q) begin
                        state_q <= ST_DECEL;
                    end
                end
                ST_ACCEL:
                begin
                    if (freq_cmd <= out_freq_q) begin
                        state_q <= ST_STEADY;
                    end else if (acc_oc_q) begin
                        ramp_hold_q <= 1'b1;
                    end else begin
                        out_freq_q <= out_freq_q + up_step;
                    end
                end
                ST_DECEL:
                begin
                    if (freq_cmd >= out_freq_q) begin
                        state_q <= ST_STEADY;
                    end else if (ov_hi_q) begin
                        ramp_hold_q <= 1'b1;
                    end else begin
                        out_freq_q <= out_freq_q - (smart ? dn_step
                            : ((out_freq_q - freq_cmd < decel_step)
                               ? out_freq_q - freq_cmd : decel_step));
                    end
                end
                ST_RUNLIM:
                begin
                    if (run_oc_q) begin
                        out_freq_q <= (out_freq_q > stall_dn) ? out_freq_q - stall_dn
                                                              : 16'h0000;
                    end else begin
                        state_q <= ST_RECOVER;
                    end
                end
                ST_RECOVER:
                begin
                    if (run_oc_q) begin
                        state_q <= ST_RUNLIM;
                    end else if (out_freq_q >= freq_cmd) begin
                        state_q <= ST_STEADY;
                    end else if (freq_cmd - out_freq_q < stall_up) begin
                        out_freq_q <= freq_cmd;
                    end else begin
                        out_freq_q <= out_freq_q + stall_up;
                    end
                end
                default: state_q <= ST_STEADY;
            endcase
        end
    end

    // extended deceleration flag: set by an over-voltage pause, kept until deceleration ends or the output reaches zero
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            decel_extended_q <= 1'b0;
        end else if (tick_q && state_q == ST_DECEL && ov_hi_q) begin
            decel_extended_q <= 1'b1;
        end else if (state_q != ST_DECEL || out_freq_q == 16'h0000) begin
            decel_extended_q <= 1'b0;
        end
    end

    // checks
    a_mode_reset: assert property (@(posedge clk_sys)
        $fell(sys_rst) |-> ov_mode_q == MODE_TRAD)
        else $error("mode not traditional after reset");
    a_trad_pause: assert property (@(posedge clk_sys) disable iff (sys_rst)
        tick_q && state_q == ST_DECEL && ov_hi_q && freq_cmd < out_freq_q
        |=> $stable(out_freq_q) && ramp_hold_q)
        else $error("deceleration moved during over-voltage");
    a_smart_ease: assert property (@(posedge clk_sys) disable iff (sys_rst)
        tick_q && state_q == ST_DECEL && smart && ov_near_q && !ov_hi_q
        && decel_step > 16'h0003 && out_freq_q - freq_cmd > decel_step
        |=> $past(out_freq_q) - out_freq_q == {1'b0, $past(decel_step[15:1])})
        else $error("smart mode did not halve the step");
    a_decel_ext: assert property (@(posedge clk_sys) disable iff (sys_rst)
        tick_q && state_q == ST_DECEL && ov_hi_q |=> decel_extended_q)
        else $error("extension flag missing");
    a_lim_range: assert property (@(posedge clk_sys) disable iff (sys_rst)
        wr_en && wr_idx == IDX_ACC_LIM && !duty_ct_q |=> acc_lim_q <= MAX_LIM_VT)
        else $error("accel limit beyond range");
    a_ct_clamp: assert property (@(posedge clk_sys) disable iff (sys_rst)
        duty_ct_q && bus_high |-> acc_lim_eff <= LIM_HIGHBUS
        && run_lim_eff <= LIM_HIGHBUS)
        else $error("high bus clamp missing");
    a_acc_freeze: assert property (@(posedge clk_sys) disable iff (sys_rst)
        tick_q && state_q == ST_ACCEL && acc_oc_q |=> $stable(out_freq_q))
        else $error("frequency rose above accel limit");
    a_run_reduce: assert property (@(posedge clk_sys) disable iff (sys_rst)
        tick_q && state_q == ST_STEADY && run_oc_q && out_freq_q != 16'h0000
        |=> out_freq_q < $past(out_freq_q) && state_q == ST_RUNLIM)
        else $error("no reduction on running over-current");
    a_run_recover: assert property (@(posedge clk_sys) disable iff (sys_rst)
        tick_q && state_q == ST_RUNLIM && !run_oc_q |=> state_q == ST_RECOVER)
        else $error("no recovery after current fell");
    a_run_range: assert property (@(posedge clk_sys) disable iff (sys_rst)
        wr_en && wr_idx == IDX_RUN_LIM
        |=> run_lim_q <= (duty_ct_q ? MAX_LIM_CT : MAX_LIM_VT))
        else $error("run limit beyond range");
    a_ov_disable: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ov_level_q == 16'h0000 && sample_valid |=> !ov_hi_q)
        else $error("over-voltage stall active at level zero");
    a_sample_tick: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !tick_q |=> $stable(out_freq_q) && $stable(state_q))
        else $error("frequency moved without a decision tick");

    c_accel_hold: cover property (@(posedge clk_sys) state_q == ST_ACCEL && ramp_hold_q);
    c_decel_ext:  cover property (@(posedge clk_sys) decel_extended_q);
    c_recover:    cover property (@(posedge clk_sys) state_q == ST_RECOVER);
endmodule : spr_ramp_ctrl
`default_nettype wire

// *** testbench/spr_plant_model.sv ***
// power stage and sensing model giving a sample every fourth clock
`timescale 1ns/1ns
`default_nettype none
module spr_plant_model
(
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic [15:0] bus_set,
    input  wire logic [15:0] cur_set,
    output logic             sample_valid,
    output logic [15:0]      bus_voltage,
    output logic [15:0]      out_current
);
    logic [1:0] div_q;
    // sample strobe; the measurements are registered on every clock, not only with it
    always_ff @(posedge clk_sys)
    begin
        div_q        <= sys_rst ? 2'h0 : div_q + 2'h1;
        sample_valid <= !sys_rst && (div_q == 2'h3);
        bus_voltage  <= bus_set;
        out_current  <= cur_set;
    end
endmodule : spr_plant_model
`default_nettype wire

// *** testbench/tb_top.sv ***
// self-checking bench for the stall prevention ramp supervisor
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import spr_pkg::*;
    logic        clk_sys = 1'b0, sys_rst = 1'b1;
    logic [15:0] s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0, freq_cmd = 16'h0;
    logic [15:0] rated_current = 16'h64, accel_step = 16'ha, decel_step = 16'ha;
    logic [15:0] stall_step = 16'h5, bus_set = 16'h1388, cur_set = 16'h32;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, sample_valid;
    logic        ramp_hold_q, decel_extended_q;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [15:0] bus_voltage, out_current, out_freq_q;
    int          error_cnt = 0, compares = 0;
    always #10 clk_sys = ~clk_sys;
    spr_ramp_ctrl u_dut (.*);
    spr_plant_model u_plant (.*);
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
            error_cnt++;
        end
    endtask : chk
    task automatic fq(input logic [15:0] e);
        chk("out_freq_q", {16'h0, e}, {16'h0, out_freq_q});
    endtask : fq
    // one write, address and data released each when taken
    task automatic axw(input logic [15:0] a, input logic [31:0] d);
        bit ta, tw, done;
        done = 1'b0;
        @(posedge clk_sys);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        for (int n = 0; n < 50 && !done; n++)
        begin
            @(negedge clk_sys);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            done = s_axi_bvalid;
            if (done) chk("bresp", {30'h0, RESP_OKAY}, {30'h0, s_axi_bresp});
            @(posedge clk_sys);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (done) s_axi_bready <= 1'b0;
        end
        chk("bvalid", 32'h1, {31'h0, done});
    endtask : axw
    // one read compared with the expected word and response
    task automatic axr(input logic [15:0] a, input logic [31:0] exp, input logic [1:0] rs);
        bit ta, done;
        done = 1'b0;
        @(posedge clk_sys);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        for (int n = 0; n < 50 && !done; n++)
        begin
            @(negedge clk_sys);
            ta = s_axi_arvalid && s_axi_arready;
            done = s_axi_rvalid;
            if (done) chk("rdata", exp, s_axi_rdata);
            if (done) chk("rresp", {30'h0, rs}, {30'h0, s_axi_rresp});
            @(posedge clk_sys);
            if (ta) s_axi_arvalid <= 1'b0;
            if (done) s_axi_rready <= 1'b0;
        end
        chk("rvalid", 32'h1, {31'h0, done});
    endtask : axr
    task automatic t_regs;
        axr({IDX_OV_MODE, 2'b00}, 32'h0, RESP_OKAY);
        axr({IDX_ACC_LIM, 2'b00}, {16'h0, RST_LIM_VT}, RESP_OKAY);
        axr({IDX_RUN_LIM, 2'b00}, {16'h0, RST_LIM_VT}, RESP_OKAY);
        axw({IDX_ACC_LIM, 2'b00}, 32'hc8);
        axr({IDX_ACC_LIM, 2'b00}, {16'h0, MAX_LIM_VT}, RESP_OKAY);
        axw({IDX_ACC_LIM, 2'b00}, {16'h0, RST_LIM_VT});
        axw({IDX_OV_MODE, 2'b00}, 32'h1);
        axr({IDX_OV_MODE, 2'b00}, {16'h0, MODE_SMART}, RESP_OKAY);
        axw({IDX_OV_MODE, 2'b00}, 32'h0);
        axr(16'h1c00, 32'h0, RESP_SLVERR);
        axw({IDX_CTRL, 2'b00}, 32'h3);
        axw({IDX_ACC_LIM, 2'b00}, 32'hd0);
        axw({IDX_RUN_LIM, 2'b00}, 32'hd0);
        axr({IDX_ACC_LIM, 2'b00}, {16'h0, MAX_LIM_CT}, RESP_OKAY);
        axr({IDX_RUN_LIM, 2'b00}, {16'h0, MAX_LIM_CT}, RESP_OKAY);
        bus_set <= 16'h1bbc;
        cur_set <= 16'hbe;
        repeat (12) @(posedge clk_sys);
        axr({IDX_STATUS, 2'b00}, 32'h4c, RESP_OKAY);
        bus_set <= 16'h1388;
        repeat (12) @(posedge clk_sys);
        axr({IDX_STATUS, 2'b00}, 32'h40, RESP_OKAY);
        axw({IDX_CTRL, 2'b00}, 32'h2);
        axw({IDX_ACC_LIM, 2'b00}, {16'h0, RST_LIM_VT});
        axw({IDX_RUN_LIM, 2'b00}, {16'h0, RST_LIM_VT});
    endtask : t_regs
    task automatic t_accel;
        cur_set  <= 16'h79;
        freq_cmd <= 16'h64;
        repeat (40) @(posedge clk_sys);
        fq(16'h0);
        chk("ramp_hold_q", 32'h1, {31'h0, ramp_hold_q});
        cur_set <= 16'h78; // equal to the limit lets it go on
        repeat (100) @(posedge clk_sys);
        fq(16'h64);
    endtask : t_accel
    task automatic t_run;
        axw({IDX_RAMP_SEL, 2'b00}, 32'h1);
        cur_set <= 16'h79;
        repeat (12) @(posedge clk_sys);
        chk("run_down", 32'h1, {31'h0, out_freq_q < 16'h64});
        cur_set <= 16'h32;
        repeat (100) @(posedge clk_sys);
        fq(16'h64);
    endtask : t_run
    task automatic t_decel;
        bus_set  <= 16'h1f40; // above the default stall level
        freq_cmd <= 16'h0;
        repeat (40) @(posedge clk_sys);
        fq(16'h64);
        chk("decel_ext", 32'h1, {31'h0, decel_extended_q});
        bus_set <= 16'h1388;
        repeat (100) @(posedge clk_sys);
        fq(16'h0);
    endtask : t_decel
    // smart mode eases the deceleration; a zero level disables the stall
    task automatic t_smart;
        axw({IDX_OV_MODE, 2'b00}, 32'h1);
        freq_cmd <= 16'h64;
        repeat (80) @(posedge clk_sys);
        bus_set  <= 16'h1d4c; // inside the band just under the stall level
        freq_cmd <= 16'h0;
        repeat (40) @(posedge clk_sys);
        chk("smart_step", 32'h1, {31'h0, out_freq_q > 16'h28 && out_freq_q < 16'h64});
        axw({IDX_OV_LEVEL, 2'b00}, 32'h0);
        bus_set <= 16'h1f40;
        repeat (100) @(posedge clk_sys);
        fq(16'h0);
    endtask : t_smart
    // reset, scenarios, verdict
    initial
    begin
        repeat (4) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_regs;
        t_accel;
        t_run;
        t_decel;
        t_smart;
        test_done;
    end
    // watchdog far beyond the expected run
    initial
    begin
        #100000;
        error_cnt++;
        test_done;
    end
    task automatic test_done;
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : test_done
endmodule : tb_top
`default_nettype wire
